// ===== hdl/frt_consts.svh
// named constants of the free-running microsecond timer
`ifndef FRT_CONSTS_SVH
`define FRT_CONSTS_SVH

// time base: device clock rate and tick period in their own units
`define FRT_CLK_MHZ       250
`define FRT_TICK_US       1
// device clock cycles per counter tick, derived from the two figures above
`define FRT_TICK_CYC      (`FRT_CLK_MHZ * `FRT_TICK_US)
`define FRT_TICK_W        8

// counter layout
`define FRT_CNT_W         12
`define FRT_CNT_RST       12'h000
`define FRT_CNT_MAX       12'hFFF
`define FRT_LO_MSB        7
`define FRT_HI_LSB        8
`define FRT_HI_W          4

// interrupt tap bits: 128 us and 1.024 ms
`define FRT_TAP_128US     6
`define FRT_TAP_1MS       9

// read-only i/o locations
`define FRT_IO_ADDR_LO    8'h24
`define FRT_IO_ADDR_HI    8'h25
`define FRT_IO_ADDR_W     8
`define FRT_IO_DATA_W     8
`define FRT_HOLD_RST      4'h0
`define FRT_DATA_RST      8'h00

`endif

// ===== hdl/frt_pkg.sv
// types shared by the free-running timer modules
package frt_pkg;

   // decoded i/o read target
   typedef enum logic [1:0] {
      FRT_RSEL_NONE,
      FRT_RSEL_LOW,
      FRT_RSEL_HIGH
   } frt_rsel_e;

   typedef logic [11:0] frt_count_t;

endpackage

// ===== hdl/frt_tick_gen.sv
// divider that turns the device clock into a one-cycle 1 us tick
`timescale 1ns/100ps
`default_nettype none
`include "frt_consts.svh"
module frt_tick_gen
   import frt_pkg::*;
(
   // clock and reset
   input  wire logic  ref_clk,
   input  wire logic  rst_n,
   // tick out
   frt_tick_if.src    tick_o
);

   localparam logic [`FRT_TICK_W-1:0] TICK_LAST = `FRT_TICK_W'(`FRT_TICK_CYC - 1);

   logic [`FRT_TICK_W-1:0] div_r;
   logic [`FRT_TICK_W-1:0] div_nxt;
   logic                   tick_r;
   logic                   tick_nxt;

   // next divider value and tick pulse
   always_comb begin
      tick_nxt = (div_r == TICK_LAST);
      div_nxt  = tick_nxt ? '0 : div_r + `FRT_TICK_W'(1);
   end

   // divider registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         div_r  <= div_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick_o.tick = tick_r;

endmodule
`default_nettype wire

// ===== hdl/frt_tick_if.sv
// carrier of the 1 us tick between tick generator and timer core
`timescale 1ns/100ps
`default_nettype none
interface frt_tick_if;
   logic tick;

   modport src (output tick);
   modport snk (input tick);
endinterface
`default_nettype wire

// ===== hdl/frt_timer.sv
// 12-bit free-running microsecond timer with latched upper nibble and tap interrupts
`timescale 1ns/100ps
`default_nettype none
`include "frt_consts.svh"
// Function
// - 12-bit counter advances once per microsecond
// - low-byte read latches upper nibble
// - upper read returns latched nibble
// - interrupt sources from bit 6, bit 9
// - raise only on enabled rising tap
// - each timer request individually maskable
// - low at 0x24, high at 0x25, read-only
module frt_timer
   import frt_pkg::*;
(
   // clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   // firmware i/o read port
   input  wire logic                       io_rd_en,
   input  wire logic [`FRT_IO_ADDR_W-1:0]  io_addr,
   output logic      [`FRT_IO_DATA_W-1:0]  io_rd_data,
   output logic                            io_rd_valid,
   // interrupt enables from the interrupt controller
   input  wire logic                       irq_en_128us,
   input  wire logic                       irq_en_1ms,
   // interrupt requests to the interrupt controller
   output logic                            irq_128us,
   output logic                            irq_1ms
);

   // decode of an i/o address into a read target
   function automatic frt_rsel_e rsel_decode(input logic                      en,
                                             input logic [`FRT_IO_ADDR_W-1:0] addr);
      frt_rsel_e sel;
      sel = FRT_RSEL_NONE;
      if (en && addr == `FRT_IO_ADDR_LO) begin
         sel = FRT_RSEL_LOW;
      end else if (en && addr == `FRT_IO_ADDR_HI) begin
         sel = FRT_RSEL_HIGH;
      end
      return sel;
   endfunction

   frt_tick_if tick_bus ();

   frt_count_t                cnt_r;
   frt_count_t                cnt_nxt;
   logic [`FRT_HI_W-1:0]      hold_r;
   logic [`FRT_HI_W-1:0]      hold_nxt;
   logic [`FRT_IO_DATA_W-1:0] rd_data_r;
   logic [`FRT_IO_DATA_W-1:0] rd_data_nxt;
   logic                      rd_valid_r;
   logic                      rd_valid_nxt;
   logic                      tap6_d_r;
   logic                      tap9_d_r;
   logic                      irq_128_r;
   logic                      irq_128_nxt;
   logic                      irq_1ms_r;
   logic                      irq_1ms_nxt;
   frt_rsel_e                 rsel;

   // 1 us time base
   frt_tick_gen u_tick (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tick_o  (tick_bus)
   );

   // counter next value: one step per tick, natural wrap
   always_comb begin
      cnt_nxt = cnt_r;
      if (tick_bus.tick) begin
         cnt_nxt = cnt_r + frt_count_t'(1);
      end
   end

   // counter register, cleared by reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= `FRT_CNT_RST;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // read path: low read latches nibble, high read returns nibble
   always_comb begin
      rsel         = rsel_decode(io_rd_en, io_addr);
      hold_nxt     = hold_r;
      rd_data_nxt  = rd_data_r;
      rd_valid_nxt = io_rd_en;
      unique case (rsel)
         FRT_RSEL_LOW: begin
            rd_data_nxt = cnt_r[`FRT_LO_MSB:0];
            hold_nxt    = cnt_r[`FRT_CNT_W-1:`FRT_HI_LSB];
         end
         FRT_RSEL_HIGH: begin
            rd_data_nxt = {{(`FRT_IO_DATA_W-`FRT_HI_W){1'b0}}, hold_r};
         end
         FRT_RSEL_NONE: begin
            rd_data_nxt = io_rd_en ? `FRT_DATA_RST : rd_data_r;
         end
         default: begin
            rd_data_nxt = `FRT_DATA_RST;
         end
      endcase
   end

   // read path registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_r     <= `FRT_HOLD_RST;
         rd_data_r  <= `FRT_DATA_RST;
         rd_valid_r <= 1'b0;
      end else begin
         hold_r     <= hold_nxt;
         rd_data_r  <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
      end
   end

   // rising-edge detection on the two tap bits, gated by enables
   always_comb begin
      irq_128_nxt = cnt_r[`FRT_TAP_128US] & ~tap6_d_r & irq_en_128us;
      irq_1ms_nxt = cnt_r[`FRT_TAP_1MS] & ~tap9_d_r & irq_en_1ms;
   end

   // tap delay and request registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tap6_d_r  <= 1'b0;
         tap9_d_r  <= 1'b0;
         irq_128_r <= 1'b0;
         irq_1ms_r <= 1'b0;
      end else begin
         tap6_d_r  <= cnt_r[`FRT_TAP_128US];
         tap9_d_r  <= cnt_r[`FRT_TAP_1MS];
         irq_128_r <= irq_128_nxt;
         irq_1ms_r <= irq_1ms_nxt;
      end
   end

   // outputs straight from flip-flops
   assign io_rd_data  = rd_data_r;
   assign io_rd_valid = rd_valid_r;
   assign irq_128us   = irq_128_r;
   assign irq_1ms     = irq_1ms_r;

   // helper: cycles since the last tick, for the tick spacing check
   logic [`FRT_TICK_W-1:0] gap_r;
   logic                   seen_r;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_r  <= '0;
         seen_r <= 1'b0;
      end else begin
         gap_r  <= tick_bus.tick ? '0 : gap_r + `FRT_TICK_W'(1);
         seen_r <= seen_r | tick_bus.tick;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // counter behaviour
   a_count_step: assert property (
      tick_bus.tick |=> cnt_r == $past(cnt_r) + frt_count_t'(1))
      else $error("counter did not step on tick");
   a_count_idle: assert property (
      !tick_bus.tick |=> $stable(cnt_r))
      else $error("counter moved without tick");
   a_tick_spacing: assert property (
      (tick_bus.tick && seen_r) |-> gap_r == `FRT_TICK_W'(`FRT_TICK_CYC - 1))
      else $error("tick spacing is not one microsecond");
   a_count_wrap: assert property (
      (tick_bus.tick && cnt_r == `FRT_CNT_MAX) |=> cnt_r == `FRT_CNT_RST)
      else $error("counter failed to wrap to zero");

   // read path
   a_low_read: assert property (
      rsel_decode(io_rd_en, io_addr) == FRT_RSEL_LOW
      |=> io_rd_valid && io_rd_data == $past(cnt_r[`FRT_LO_MSB:0]))
      else $error("low read returned wrong byte");
   a_hold_capture: assert property (
      rsel_decode(io_rd_en, io_addr) == FRT_RSEL_LOW
      |=> hold_r == $past(cnt_r[`FRT_CNT_W-1:`FRT_HI_LSB]))
      else $error("upper nibble not latched on low read");
   a_high_from_hold: assert property (
      rsel_decode(io_rd_en, io_addr) == FRT_RSEL_HIGH
      |=> io_rd_valid && io_rd_data == {4'h0, $past(hold_r)})
      else $error("high read did not return latched nibble");

   // interrupt requests
   a_irq128_cause: assert property (
      irq_128us |-> $past(cnt_r[`FRT_TAP_128US]) && !$past(cnt_r[`FRT_TAP_128US], 2)
                    && $past(irq_en_128us))
      else $error("128 us request without enabled rising tap");
   a_irq1ms_cause: assert property (
      irq_1ms |-> $past(cnt_r[`FRT_TAP_1MS]) && !$past(cnt_r[`FRT_TAP_1MS], 2)
                  && $past(irq_en_1ms))
      else $error("1 ms request without enabled rising tap");
   a_irq128_rise: assert property (
      ($rose(cnt_r[`FRT_TAP_128US]) && irq_en_128us) |=> irq_128us ##1 !irq_128us)
      else $error("enabled 128 us rise missed or not a pulse");
   a_irq1ms_rise: assert property (
      ($rose(cnt_r[`FRT_TAP_1MS]) && irq_en_1ms) |=> irq_1ms ##1 !irq_1ms)
      else $error("enabled 1 ms rise missed or not a pulse");
   // each source masked on its own, whatever the other enable does
   a_irq_masked: assert property (
      !irq_en_128us |=> !irq_128us)
      else $error("masked 128 us request raised");
   a_irq1ms_masked: assert property (
      !irq_en_1ms |=> !irq_1ms)
      else $error("masked 1 ms request raised");

   cover_low_then_high: cover property (
      rsel_decode(io_rd_en, io_addr) == FRT_RSEL_LOW ##[1:8]
      rsel_decode(io_rd_en, io_addr) == FRT_RSEL_HIGH);
   cover_irq_128: cover property (irq_128us);
   cover_wrap: cover property (tick_bus.tick && cnt_r == `FRT_CNT_MAX);

endmodule
`default_nettype wire

// ===== tb/free_running_usec_timer_tb_top.sv
// self-checking bench of the free-running microsecond timer
`timescale 1ns/100ps
`default_nettype none
`include "frt_consts.svh"
module free_running_usec_timer_tb_top
   import frt_pkg::*;
;
   // clock and reset
   logic                        ref_clk = 1'b0;
   logic                        rst_n   = 1'b0;
   // read port and interrupt lines
   logic                        io_rd_en     = 1'b0;
   logic [`FRT_IO_ADDR_W-1:0]   io_addr      = 8'h00;
   logic [`FRT_IO_DATA_W-1:0]   io_rd_data;
   logic                        io_rd_valid;
   logic                        irq_en_128us = 1'b1;
   logic                        irq_en_1ms   = 1'b1;
   logic                        irq_128us;
   logic                        irq_1ms;
   // bench bookkeeping
   int                          error_cnt = 0;
   int                          compares  = 0;
   int                          cyc       = 0;
   int                          n128      = 0;
   int                          n1ms      = 0;
   int                          first128  = 0;
   logic                        prev128   = 1'b0;
   logic [7:0]                  rd;
   logic [7:0]                  lo0;
   int                          n;

   // 4 ns clock
   always #2 ref_clk = ~ref_clk;

   frt_timer dut_u (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .io_rd_en     (io_rd_en),
      .io_addr      (io_addr),
      .io_rd_data   (io_rd_data),
      .io_rd_valid  (io_rd_valid),
      .irq_en_128us (irq_en_128us),
      .irq_en_1ms   (irq_en_1ms),
      .irq_128us    (irq_128us),
      .irq_1ms      (irq_1ms)
   );

   // one compare, counted
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
         error_cnt++;
      end
   endtask

   // elapsed ticks over n cycles may straddle one tick boundary
   function automatic logic diff_ok(input int cycles, input logic [7:0] d);
      return (d == 8'((cycles) / 250)) || (d == 8'((cycles) / 250 + 1));
   endfunction

   // one read: strobe for one edge, answer checked one cycle later
   task automatic io_read(input logic [7:0] a, output logic [7:0] d);
      io_rd_en = 1'b1;
      io_addr  = a;
      @(negedge ref_clk);
      io_rd_en = 1'b0;
      chk(io_rd_valid, 1'b1);
      d = io_rd_data;
      @(negedge ref_clk);
      chk(io_rd_valid, 1'b0);
   endtask

   task automatic wait_until(input int c);
      while (cyc < c) @(negedge ref_clk);
   endtask

   // verdict and end of run
   task automatic test_done();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // interrupt pulse monitor
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      prev128 <= irq_128us;
      if (irq_128us === 1'b1) begin
         n128 <= n128 + 1;
         if (n128 == 0) first128 <= cyc;
         if (prev128 === 1'b1) chk(1'b1, 1'b0);
      end
      if (irq_1ms === 1'b1) n1ms <= n1ms + 1;
   end

   // watchdog
   initial begin
      #400000;
      error_cnt++;
      test_done();
   end

   // main sequence
   initial begin
      void'($urandom(8));
      repeat (2) @(negedge ref_clk);
      chk({io_rd_valid, irq_128us, irq_1ms, io_rd_data}, 12'h000);
      rst_n = 1'b1;
      @(negedge ref_clk);
      io_read(`FRT_IO_ADDR_HI, rd);
      chk(rd, 8'h00);
      io_read(`FRT_IO_ADDR_LO, rd);
      chk(rd, 8'h00);
      // unmapped addresses answer zero and leave the nibble alone
      for (int i = 0; i < 6; i++) begin
         n = $urandom;
         if (8'(n) == `FRT_IO_ADDR_LO || 8'(n) == `FRT_IO_ADDR_HI) n = 8'h30;
         io_read(8'(n), rd);
         chk(rd, 8'h00);
      end
      // random intervals measured by two low reads
      for (int i = 0; i < 4; i++) begin
         n = 250 + $urandom % 2000;
         io_read(`FRT_IO_ADDR_LO, lo0);
         repeat (n) @(negedge ref_clk);
         io_read(`FRT_IO_ADDR_LO, rd);
         chk(diff_ok(n + 2, rd - lo0), 1'b1);
      end
      wait_until(30000);
      chk(n128, 1);
      chk(first128 >= 15990 && first128 <= 16260, 1'b1);
      // tap bit 6 falls at count 128 while still enabled: no request
      wait_until(40000);
      chk(n128, 1);
      irq_en_128us = 1'b0;
      irq_en_1ms   = 1'b0;
      // low read just before the nibble carry, high read after it
      wait_until(63500);
      io_read(`FRT_IO_ADDR_LO, rd);
      chk(rd >= 8'hF8, 1'b1);
      wait_until(65500);
      io_read(`FRT_IO_ADDR_HI, rd);
      chk(rd, 8'h00);
      io_read(`FRT_IO_ADDR_LO, rd);
      // an unmapped read between must leave the latched nibble alone
      io_read(8'h30, rd);
      chk(rd, 8'h00);
      io_read(`FRT_IO_ADDR_HI, rd);
      chk(rd, 8'h01);
      chk(n128, 1);
      irq_en_128us = 1'b1;
      irq_en_1ms   = 1'b1;
      wait_until(85000);
      chk(n128, 2);
      chk(n1ms, 0);
      // second reset in mid-run clears counter and nibble
      rst_n = 1'b0;
      @(negedge ref_clk);
      chk({io_rd_valid, irq_128us, irq_1ms, io_rd_data}, 12'h000);
      rst_n = 1'b1;
      @(negedge ref_clk);
      io_read(`FRT_IO_ADDR_HI, rd);
      chk(rd, 8'h00);
      io_read(`FRT_IO_ADDR_LO, rd);
      chk(rd, 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
